// ### include/mrf_cfg.svh
// offsets, field positions, reset values and timing counts of the mode register block
`ifndef MRF_CFG_SVH
`define MRF_CFG_SVH
`define MRF_OFF_MR0 5'h00
`define MRF_OFF_MR1 5'h04
`define MRF_OFF_MR2 5'h08
`define MRF_OFF_STAT 5'h0C
`define MRF_OFF_CTRL 5'h10
`define MRF_MR0_TEST 7
`define MRF_MR0_DLLRST 8
`define MRF_MR0_WR_LO 9
`define MRF_MR1_DLLEN 0
`define MRF_MR1_AL_LO 3
`define MRF_MR1_EXTRA_TERMINATION_STROBE 11
`define MRF_MR1_QOFF 12
`define MRF_MR2_CWL_LO 3
`define MRF_MR2_RTTWR_LO 9
`define MRF_CTRL_RST 8'h00
`define MRF_CL_BASE 9
`define MRF_BURST_CYC 4
`define MRF_PRE_CYC 10
`define MRF_LOCK_CYC 1024
`endif

// ### include/mrf_pkg.sv
// types shared by the mode register block
package mrf_pkg;
    typedef enum logic [2:0] {
        MRF_DLL_OFF = 3'b001,
        MRF_DLL_LOCKING = 3'b010,
        MRF_DLL_LOCKED = 3'b100
    } mrf_dll_t;
endpackage

// ### core/mrf_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module mrf_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk_i, // block clock
    input wire logic sys_rst_i, // sync reset, active high
    input wire logic [W-1:0] d_i, // asynchronous pins
    output logic [W-1:0] q_o // synchronised pins
);
    logic [W-1:0] meta_q;
    // first stage is read by the second stage only
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule // mrf_sync

// ### core/mrf_lat.sv
// command delay line stepped by link clock enables
`timescale 1ns/1ps
module mrf_lat #(
    parameter int DEPTH = 64
) (
    input wire logic ref_clk_i, // block clock
    input wire logic sys_rst_i, // sync reset, active high
    input wire logic step_i, // one link cycle elapsed
    input wire logic cmd_i, // command taken this link cycle
    input wire logic [5:0] tap_i, // latency in link cycles
    output logic due_o // pulse: latency reached
);
    if (DEPTH < 2 || DEPTH > 64) $error("mrf_lat: DEPTH out of range");
    logic [DEPTH-1:0] sr_q;
    // whole-cycle taps only, no half-cycle stage exists
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            sr_q <= '0;
        end else if (step_i) begin
            sr_q <= {sr_q[DEPTH-2:0], cmd_i};
        end
    end
    // tap 0 would be the command edge itself, never used
    assign due_o = step_i && (tap_i != 6'h00) && sr_q[tap_i - 6'h01];
endmodule // mrf_lat

// ### core/mrf_core.sv
// device-side mode register zero/one logic with command decode and latency timing
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "mrf_cfg.svh"
module mrf_core import mrf_pkg::*; #(
    parameter int LOCK_CYC = `MRF_LOCK_CYC,
    parameter int LAT_DEPTH = 64
) (
    input wire logic ref_clk_i, // 25 MHz block clock
    input wire logic sys_rst_i, // sync reset, active high
    input wire logic [4:0] avs_address_i, // byte address
    input wire logic avs_read_i, // read request
    input wire logic avs_write_i, // write request
    input wire logic [3:0] avs_byteenable_i, // byte lanes
    input wire logic [31:0] avs_writedata_i, // write data
    output logic [31:0] avs_readdata_o, // read data
    output logic avs_waitrequest_o, // stall
    input wire logic ck_i, // link clock pin
    input wire logic cke_i, // clock enable pin
    input wire logic cs_n_i, // chip select, active low
    input wire logic act_n_i, // activate, active low
    input wire logic ras_n_i, // row strobe, active low
    input wire logic cas_n_i, // column strobe, active low
    input wire logic we_n_i, // write enable, active low
    input wire logic group_select_i, // group select pin
    input wire logic [1:0] bank_select_bits_i, // bank pins
    input wire logic [13:0] addr_i, // address pins
    input wire logic odt_i, // termination pin
    input wire logic wr_crc_err_i, // crc error of current store
    output logic dq_oe_o, // drive data/strobe pins
    output logic wr_commit_o, // pulse: store data into array
    output logic wr_drop_o, // pulse: store blocked by crc
    output logic [1:0] drive_imp_o, // driver impedance code
    output logic [2:0] rtt_sel_o, // termination on data pins
    output logic [2:0] strobe_term_o, // termination on strobe pins
    output logic byte_mask_en_o, // byte mask usable
    output logic bus_inversion_en_o, // bus inversion usable
    output logic dll_active_o, // loop running
    output logic dll_locked_o, // loop lock time met
    output logic test_mode_o, // test mode entered
    output logic [5:0] act_delay_o // store-precharge-activate cycles
);
    if (LOCK_CYC < 1 || LAT_DEPTH < 48) $error("mrf_core: bad parameters");
    // recovery code to cycles, 111 reserved
    function automatic logic [4:0] wr_cyc(input logic [2:0] c);
        unique case (c)
            3'h0: wr_cyc = 5'd10;
            3'h1: wr_cyc = 5'd12;
            3'h2: wr_cyc = 5'd14;
            3'h3: wr_cyc = 5'd16;
            3'h4: wr_cyc = 5'd18;
            3'h5: wr_cyc = 5'd20;
            3'h6, 3'h7: wr_cyc = 5'd24;
        endcase
    endfunction
    // store column latency code to cycles
    function automatic logic [5:0] cwl_cyc(input logic [2:0] c);
        unique case (c)
            3'h0: cwl_cyc = 6'd9;
            3'h1: cwl_cyc = 6'd10;
            3'h2: cwl_cyc = 6'd11;
            3'h3: cwl_cyc = 6'd12;
            3'h4: cwl_cyc = 6'd14;
            3'h5: cwl_cyc = 6'd16;
            3'h6, 3'h7: cwl_cyc = 6'd18;
        endcase
    endfunction
    // added delay from read column latency and code
    function automatic logic [5:0] al_cyc(input logic [1:0] c, input logic [5:0] cl);
        unique case (c)
            2'h1: al_cyc = cl - 6'd1;
            2'h2: al_cyc = cl - 6'd2;
            default: al_cyc = 6'd0;
        endcase
    endfunction
    // pins through two flip-flops
    logic [24:0] pin_s;
    mrf_sync #(.W(25)) u_sync (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i({ck_i, cke_i, cs_n_i, act_n_i, ras_n_i, cas_n_i, we_n_i, group_select_i,
              bank_select_bits_i, addr_i, odt_i}),
        .q_o(pin_s)
    );
    logic ck_s, cke_s, cs_n_s, act_n_s, ras_n_s, cas_n_s, we_n_s, odt_s;
    logic [2:0] sel_s;
    logic [13:0] addr_s;
    assign {ck_s, cke_s, cs_n_s, act_n_s, ras_n_s, cas_n_s, we_n_s} = pin_s[24:18];
    assign sel_s = pin_s[17:15];
    assign addr_s = pin_s[14:1];
    assign odt_s = pin_s[0];
    // rising edge of the sampled link clock
    logic ck_prev_q;
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) ck_prev_q <= 1'b0;
        else ck_prev_q <= ck_s;
    end
    logic step;
    assign step = ck_s && !ck_prev_q;
    // command decode at each link rising edge
    logic cmd_ok, is_mrs, is_rd, is_wr, is_ref;
    assign cmd_ok = step && !cs_n_s && act_n_s;
    assign is_mrs = cmd_ok && !ras_n_s && !cas_n_s && !we_n_s;
    assign is_ref = cmd_ok && !ras_n_s && !cas_n_s && we_n_s;
    assign is_rd = cmd_ok && ras_n_s && !cas_n_s && we_n_s;
    assign is_wr = cmd_ok && ras_n_s && !cas_n_s && !we_n_s;
    // mode register shadows; select 111 never answered
    logic [13:0] mr0_q, mr1_q, mr2_q;
    logic mrs_hit;
    assign mrs_hit = is_mrs && (sel_s != 3'b111);
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            mr0_q <= '0;
            mr1_q <= '0;
            mr2_q <= '0;
        end else begin
            if (mrs_hit && sel_s == 3'b000) begin
                mr0_q <= addr_s;
                mr0_q[`MRF_MR0_DLLRST] <= 1'b0;
            end else if (mrs_hit && sel_s == 3'b001) begin
                mr1_q <= addr_s;
            end else if (mrs_hit && sel_s == 3'b010) begin
                mr2_q <= addr_s;
            end
        end
    end
    logic dll_rst_req;
    assign dll_rst_req = mrs_hit && sel_s == 3'b000 && addr_s[`MRF_MR0_DLLRST];
    // no functional change; the flag only reports entry
    assign test_mode_o = mr0_q[`MRF_MR0_TEST];
    // derived latencies, all whole cycles
    logic [5:0] cl, al, store_column_latency, rl, wl;
    assign cl = 6'(`MRF_CL_BASE) + {2'b00, mr0_q[6:4], mr0_q[2]};
    assign al = al_cyc(mr1_q[`MRF_MR1_AL_LO +: 2], cl);
    assign store_column_latency = cwl_cyc(mr2_q[`MRF_MR2_CWL_LO +: 3]);
    assign rl = al + cl;
    assign wl = al + store_column_latency;
    // recovery field plus precharge time gives the activate delay
    localparam logic [5:0] PRE_CYC = 6'(`MRF_PRE_CYC);
    assign act_delay_o = {1'b0, wr_cyc(mr0_q[`MRF_MR0_WR_LO +: 3])} + PRE_CYC;
    // self refresh follows refresh with cke low, ends when cke returns
    logic self_ref_q;
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) self_ref_q <= 1'b0;
        else if (is_ref && !cke_s) self_ref_q <= 1'b1;
        else if (step && cke_s) self_ref_q <= 1'b0;
    end
    assign dll_active_o = mr1_q[`MRF_MR1_DLLEN] && !self_ref_q;
    // loop lock sequencing counted in link cycles
    mrf_dll_t dll_q;
    logic [15:0] lock_cnt_q;
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            dll_q <= MRF_DLL_OFF;
            lock_cnt_q <= '0;
        end else if (!dll_active_o) begin
            dll_q <= MRF_DLL_OFF;
        end else begin
            unique case (dll_q)
                MRF_DLL_OFF: if (dll_rst_req) begin
                    dll_q <= MRF_DLL_LOCKING;
                    lock_cnt_q <= '0;
                end
                // lock wait assumes cke held high by the controller
                MRF_DLL_LOCKING: if (step) begin
                    if (lock_cnt_q == 16'(LOCK_CYC - 1)) dll_q <= MRF_DLL_LOCKED;
                    lock_cnt_q <= lock_cnt_q + 16'h0001;
                end
                MRF_DLL_LOCKED: if (dll_rst_req) begin
                    dll_q <= MRF_DLL_LOCKING;
                    lock_cnt_q <= '0;
                end
                default: dll_q <= MRF_DLL_OFF;
            endcase
        end
    end
    assign dll_locked_o = dll_active_o && (dll_q == MRF_DLL_LOCKED);
    // commands wait added delay plus column latency inside
    logic rd_due, wr_due;
    mrf_lat #(.DEPTH(LAT_DEPTH)) u_rd_lat (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .step_i(step),
        .cmd_i(is_rd),
        .tap_i(rl),
        .due_o(rd_due)
    );
    mrf_lat #(.DEPTH(LAT_DEPTH)) u_wr_lat (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .step_i(step),
        .cmd_i(is_wr),
        .tap_i(wl),
        .due_o(wr_due)
    );
    // burst windows, four link cycles each
    logic [2:0] rd_win_q, wr_win_q;
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) rd_win_q <= '0;
        else if (rd_due) rd_win_q <= 3'(`MRF_BURST_CYC);
        else if (step && rd_win_q != 3'h0) rd_win_q <= rd_win_q - 3'h1;
    end
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) wr_win_q <= '0;
        else if (wr_due) wr_win_q <= 3'(`MRF_BURST_CYC);
        else if (step && wr_win_q != 3'h0) wr_win_q <= wr_win_q - 3'h1;
    end
    // pins disconnected when output-off bit set
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) dq_oe_o <= 1'b0;
        else dq_oe_o <= (rd_due || (rd_win_q > 3'h1) || (rd_win_q == 3'h1 && !step))
                        && !mr1_q[`MRF_MR1_QOFF];
    end
    // control register: pin-sharing enables and park value
    logic [7:0] ctrl_q;
    logic crc_en, extra_termination_strobe_en;
    assign crc_en = ctrl_q[3];
    assign extra_termination_strobe_en = mr1_q[`MRF_MR1_EXTRA_TERMINATION_STROBE];
    assign byte_mask_en_o = ctrl_q[0] && !extra_termination_strobe_en;
    assign bus_inversion_en_o = (ctrl_q[1] || ctrl_q[2]) && !extra_termination_strobe_en;
    // store committed at end of burst unless crc failed with mask on
    logic wr_end;
    assign wr_end = step && wr_win_q == 3'h1;
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            wr_commit_o <= 1'b0;
            wr_drop_o <= 1'b0;
        end else begin
            wr_commit_o <= wr_end && !(crc_en && byte_mask_en_o && wr_crc_err_i);
            wr_drop_o <= wr_end && crc_en && byte_mask_en_o && wr_crc_err_i;
        end
    end
    // impedance code taken straight from the shadow
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) drive_imp_o <= 2'b00;
        else drive_imp_o <= mr1_q[2:1];
    end
    // termination choice: store value in writes, nominal with odt, park with odt low, else off
    logic [2:0] nominal_termination, store_termination, rtt_next;
    assign nominal_termination = {mr1_q[9], mr1_q[6], mr1_q[2]};
    assign store_termination = {1'b0, mr2_q[`MRF_MR2_RTTWR_LO +: 2]};
    always_comb begin
        if (wr_win_q != 3'h0 && store_termination != 3'h0) rtt_next = store_termination;
        else if (odt_s && nominal_termination != 3'h0) rtt_next = nominal_termination;
        else if (!odt_s) rtt_next = ctrl_q[6:4];
        else rtt_next = 3'h0;
    end
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rtt_sel_o <= 3'h0;
            strobe_term_o <= 3'h0;
        end else begin
            rtt_sel_o <= rtt_next;
            strobe_term_o <= extra_termination_strobe_en ? rtt_next : 3'h0;
        end
    end
    // bus slave: one wait cycle, answer on the second edge
    logic ack_q;
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) ack_q <= 1'b0;
        else ack_q <= (avs_read_i || avs_write_i) && !ack_q;
    end
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) ctrl_q <= `MRF_CTRL_RST;
        else if (avs_write_i && ack_q && avs_address_i == `MRF_OFF_CTRL && avs_byteenable_i[0])
            ctrl_q <= {1'b0, avs_writedata_i[6:4], avs_writedata_i[3:0]};
    end
    // unmapped addresses read zero
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) avs_readdata_o <= '0;
        else if (avs_read_i && !ack_q) begin
            unique case (avs_address_i)
                `MRF_OFF_MR0: avs_readdata_o <= {18'h0_0000, mr0_q};
                `MRF_OFF_MR1: avs_readdata_o <= {18'h0_0000, mr1_q};
                `MRF_OFF_MR2: avs_readdata_o <= {18'h0_0000, mr2_q};
                `MRF_OFF_STAT: avs_readdata_o <= {10'h000, wl, 2'b00, rl, 4'h0,
                                                  dll_active_o, test_mode_o, self_ref_q,
                                                  dll_locked_o};
                `MRF_OFF_CTRL: avs_readdata_o <= {24'h00_0000, ctrl_q};
                default: avs_readdata_o <= '0;
            endcase
        end
    end
    // helper: link cycles since last read and write command
    logic [6:0] rd_age_q, wr_age_q;
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || is_rd) rd_age_q <= '0;
        else if (step && rd_age_q != 7'h7F) rd_age_q <= rd_age_q + 7'h01;
    end
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || is_wr) wr_age_q <= '0;
        else if (step && wr_age_q != 7'h7F) wr_age_q <= wr_age_q + 7'h01;
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_rd_lat;
        rd_due && !is_rd |-> rd_age_q == {1'b0, rl} - 7'h01;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read due at wrong latency");
    property p_wr_lat;
        wr_due && !is_wr |-> wr_age_q == {1'b0, wl} - 7'h01;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("store due at wrong latency");
    property p_dll_clr;
        dll_rst_req |=> !mr0_q[`MRF_MR0_DLLRST] ##1 !mr0_q[`MRF_MR0_DLLRST];
    endproperty
    a_dll_clr: assert property (p_dll_clr) else $error("loop reset bit stuck");
    property p_ignore;
        is_mrs && sel_s == 3'b111 |=> $stable(mr0_q) && $stable(mr1_q) && $stable(mr2_q);
    endproperty
    a_ignore: assert property (p_ignore) else $error("select 111 changed a register");
    property p_sr_off;
        is_ref && !cke_s |=> !dll_active_o && !dll_locked_o;
    endproperty
    a_sr_off: assert property (p_sr_off) else $error("loop on in self refresh");
    property p_qoff;
        mr1_q[`MRF_MR1_QOFF] ##1 mr1_q[`MRF_MR1_QOFF] |-> !dq_oe_o;
    endproperty
    a_qoff: assert property (p_qoff) else $error("outputs driven while disabled");
    property p_share;
        extra_termination_strobe_en |-> !byte_mask_en_o && !bus_inversion_en_o;
    endproperty
    a_share: assert property (p_share) else $error("shared pin double use");
    property p_strobe;
        $past(extra_termination_strobe_en) |-> strobe_term_o == rtt_sel_o;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe termination differs");
    property p_crc;
        wr_end && crc_en && byte_mask_en_o && wr_crc_err_i |=> wr_drop_o && !wr_commit_o;
    endproperty
    a_crc: assert property (p_crc) else $error("bad crc store committed");
    property p_imp;
        mrs_hit && sel_s == 3'b001 |=> ##1 drive_imp_o == $past(addr_s[2:1], 2);
    endproperty
    a_imp: assert property (p_imp) else $error("impedance not taken");
    property p_park;
        !odt_s && wr_win_q == 3'h0 |=> rtt_sel_o == $past(ctrl_q[6:4]);
    endproperty
    a_park: assert property (p_park) else $error("park termination missing");
endmodule // mrf_core

// ### verif/mrf_ctl_model.sv
// controller model: free-running link clock and command pins
`timescale 1ns/1ps
module mrf_ctl_model (
    output logic ck_o, // link clock, 320 ns period
    output logic cke_o, // clock enable
    output logic cs_n_o, // chip select, active low
    output logic act_n_o, // activate, active low
    output logic [2:0] cmd_n_o, // row, column, write strobes
    output logic [2:0] sel_o, // group select and bank bits
    output logic [13:0] addr_o // address pins
);
    // idle: deselected, clock enable high so a lock can run
    initial begin
        ck_o = 1'b0;
        cke_o = 1'b1;
        cs_n_o = 1'b1;
        act_n_o = 1'b1;
        cmd_n_o = 3'b111;
        sel_o = 3'b000;
        addr_o = 14'h0000;
    end
    // link clock runs free, as on a real controller
    always #160 ck_o = ~ck_o;
    // one command around one rising edge; callers zero unused bits
    task automatic cmd(input logic cs, input logic [2:0] op, input logic [2:0] sel,
                       input logic [13:0] a, input logic ke);
        @(negedge ck_o);
        cs_n_o <= ~cs;
        cmd_n_o <= op;
        sel_o <= sel;
        addr_o <= a;
        cke_o <= ke;
        @(negedge ck_o);
        // released lines show the inverse so stale values never match
        cs_n_o <= 1'b1;
        cmd_n_o <= ~op;
        sel_o <= ~sel;
        addr_o <= ~a;
        @(negedge ck_o);
    endtask
endmodule // mrf_ctl_model

// ### verif/sdram_mode_reg_zero_one_functions_test.sv
// self-checking bench for the mode register block
`timescale 1ns/1ps
`include "mrf_cfg.svh"
module sdram_mode_reg_zero_one_functions_test;
    logic clk = 1'b0, rst = 1'b1, rd_q, wr_q, err_q, odt_q;
    logic [4:0] adr_q;
    logic [31:0] wd_q, rdat, q;
    logic ck, cke, cs_n, act_n, wreq, dq_oe, commit, drop, bm, bi, act, lck, tm;
    logic [2:0] cmd_n, sel, rtt, sterm;
    logic [13:0] a;
    logic [1:0] imp;
    logic [5:0] dly;
    int fail_count = 0, check_count = 0, n, hit;
    int wr_tab[8] = '{10, 12, 14, 16, 18, 20, 24, 24};
    int lt_mr0[4] = '{0, 0, 0, 'h10};
    int lt_mr1[4] = '{1, 9, 'h11, 1};
    int lt_rl[4] = '{9, 17, 16, 11};
    // 25 MHz block clock
    always #20 clk = ~clk;
    mrf_ctl_model i_ctl (.ck_o(ck), .cke_o(cke), .cs_n_o(cs_n), .act_n_o(act_n),
        .cmd_n_o(cmd_n), .sel_o(sel), .addr_o(a));
    mrf_core #(.LOCK_CYC(8), .LAT_DEPTH(64)) i_dut (.ref_clk_i(clk), .sys_rst_i(rst),
        .avs_address_i(adr_q), .avs_read_i(rd_q), .avs_write_i(wr_q),
        .avs_byteenable_i(4'h1), .avs_writedata_i(wd_q), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .ck_i(ck), .cke_i(cke), .cs_n_i(cs_n), .act_n_i(act_n),
        .ras_n_i(cmd_n[2]), .cas_n_i(cmd_n[1]), .we_n_i(cmd_n[0]), .group_select_i(sel[2]),
        .bank_select_bits_i(sel[1:0]), .addr_i(a), .odt_i(odt_q), .wr_crc_err_i(err_q),
        .dq_oe_o(dq_oe), .wr_commit_o(commit), .wr_drop_o(drop), .drive_imp_o(imp),
        .rtt_sel_o(rtt), .strobe_term_o(sterm), .byte_mask_en_o(bm),
        .bus_inversion_en_o(bi), .dll_active_o(act), .dll_locked_o(lck),
        .test_mode_o(tm), .act_delay_o(dly));
    // verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic tmo();
        fail_count++;
        $display("BAD %0t wait ran out", $time);
        test_done();
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one bus cycle, held until waitrequest is seen low
    task automatic av(input logic w, input logic [4:0] ad, input logic [31:0] d,
                      output logic [31:0] r);
        int k;
        @(posedge clk);
        adr_q <= ad;
        wd_q <= d;
        wr_q <= w;
        rd_q <= ~w;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wreq !== 1'b0 && k < 50);
        if (k >= 50) tmo();
        r = rdat;
        rd_q <= 1'b0;
        wr_q <= 1'b0;
    endtask
    task automatic m(input logic [2:0] s, input logic [13:0] ad);
        i_ctl.cmd(1'b1, 3'b000, s, ad, 1'b1);
    endtask
    initial begin
        rd_q = 1'b0;
        wr_q = 1'b0;
        adr_q = 5'h00;
        wd_q = 32'h0000_0000;
        err_q = 1'b0;
        odt_q = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk(32'({dq_oe, commit, drop, imp, rtt, sterm, bm, bi, act, lck, tm}), 0);
        av(1'b0, 5'h14, 0, q);
        chk(q, 0);
        av(1'b1, `MRF_OFF_CTRL, 32'hFFFF_FF7D, q);
        av(1'b0, `MRF_OFF_CTRL, 0, q);
        chk(q, 'h7D);
        av(1'b1, `MRF_OFF_MR1, 32'h0000_FFFF, q);
        av(1'b0, `MRF_OFF_MR1, 0, q);
        chk(q, 0);
        $display("test registers done");
        m(3'b001, 14'h0004);
        chk(32'(imp), 2);
        chk(32'(rtt), 7);
        chk(32'({bm, bi}), 3);
        @(posedge clk) odt_q <= 1'b1;
        repeat (8) @(posedge clk);
        chk(32'(rtt), 1);
        m(3'b001, 14'h0804); // by-8 part, extra strobe allowed
        chk(32'(sterm), 1);
        chk(32'({bm, bi}), 0);
        m(3'b111, 14'h1000);
        av(1'b0, `MRF_OFF_MR1, 0, q);
        chk(q, 'h0804);
        @(posedge clk) odt_q <= 1'b0;
        $display("test mode_reg_one done");
        foreach (wr_tab[i]) begin
            m(3'b000, 14'(i << 9));
            chk(32'(dly), wr_tab[i] + `MRF_PRE_CYC);
        end
        m(3'b000, 14'h0080);
        chk(32'(tm), 1);
        m(3'b000, 14'h0000); // recovery code at least minimum
        chk(32'(tm), 0);
        $display("test mode_reg_zero done");
        m(3'b001, 14'h0001);
        m(3'b000, 14'h0100);
        av(1'b0, `MRF_OFF_MR0, 0, q);
        chk(q, 0);
        chk(32'(lck), 0);
        n = 1;
        while (lck !== 1'b1 && n < 40) begin
            @(posedge ck);
            n++;
        end
        if (n >= 40) tmo();
        chk(32'(n > 7 && n < 12), 1);
        $display("test lock done");
        for (int i = 0; i < 4; i++) begin
            m(3'b000, 14'(lt_mr0[i]));
            m(3'b001, 14'(lt_mr1[i]));
            av(1'b0, `MRF_OFF_STAT, 0, q);
            chk(32'(q[13:8]), lt_rl[i]);
            i_ctl.cmd(1'b1, 3'b101, 3'b000, 14'h0000, 1'b1); // read after lock
            n = 1;
            while (dq_oe !== 1'b1 && n < 60) begin
                @(posedge ck);
                n++;
            end
            if (n >= 60) tmo();
            chk(n, lt_rl[i] + 1);
            repeat (6) @(posedge ck);
        end
        $display("test read latency done");
        m(3'b000, 14'h0000);
        m(3'b010, 14'h0208); // store termination code 01 while the loop runs
        av(1'b0, `MRF_OFF_STAT, 0, q);
        chk(32'(q[21:16]), 10);
        for (int e = 1; e >= 0; e--) begin
            @(posedge clk) err_q <= e[0];
            i_ctl.cmd(1'b1, 3'b100, 3'b000, 14'h0000, 1'b1);
            n = 0;
            hit = 0;
            while (commit !== 1'b1 && drop !== 1'b1 && n < 3000) begin
                @(posedge clk);
                if (rtt === 3'h1) hit++;
                n++;
            end
            if (n >= 3000) tmo();
            chk(32'({commit, drop}), (e == 1) ? 1 : 2);
            chk(32'(hit > 0), 1);
            repeat (6) @(posedge ck);
        end
        m(3'b010, 14'h0008); // store termination off
        $display("test store done");
        m(3'b001, 14'h1001);
        i_ctl.cmd(1'b1, 3'b101, 3'b000, 14'h0000, 1'b1);
        n = 0;
        repeat (30) begin
            @(posedge ck);
            if (dq_oe !== 1'b0) n++;
        end
        chk(n, 0);
        $display("test output disable done");
        m(3'b001, 14'h0001);
        chk(32'(act), 1);
        i_ctl.cmd(1'b1, 3'b001, 3'b000, 14'h0000, 1'b0); // cke held low
        chk(32'(act), 0);
        i_ctl.cmd(1'b0, 3'b111, 3'b000, 14'h0000, 1'b1);
        chk(32'(act), 1);
        $display("test self refresh done");
        test_done();
    end
endmodule // sdram_mode_reg_zero_one_functions_test
